// ==== rtl/dtg_pkg.sv ====
package dtg_pkg;

    // Byte addresses of the two tone-code registers on the control port.
    localparam logic [7:0] HI_TONE_OFS = 8'h04;
    localparam logic [7:0] LO_TONE_OFS = 8'h05;
    // Both tone codes come out of reset as silence.
    localparam logic [7:0] CODE_RST    = 8'h00;

    // The phase accumulator is ten bits wide, so one code step is frame rate / 1024.
    localparam int PHASE_W    = 10;
    // Width of the linear sample handed to the receive path.
    localparam int SAMPLE_W   = 15;
    // Widths of the low-tone and high-tone table amplitudes.
    localparam int LO_W       = 6;
    localparam int HI_W       = 7;
    // Number of zero bits appended below the table amplitude.
    localparam int PAD_LSB    = 7;
    // Depth of the sample buffer in front of the receive path.
    localparam int FIFO_DEPTH = 4;
    // Frame rate and master clock rate; their ratio is the nominal frame spacing in cycles.
    localparam int FRAME_HZ   = 8000;
    localparam int MCLK_HZ    = 10000000;
    localparam int FRAME_CYC  = MCLK_HZ / FRAME_HZ;
    // Low-tone amplitude limits.
    localparam int LO_MAX     = 31;
    localparam int LO_MIN     = -32;
    // High-tone amplitude limits.
    localparam int HI_MAX     = 39;
    localparam int HI_MIN     = -40;
    // Full-scale feedback level of the density modulator.
    localparam logic [16:0] SD_FS = 17'h0_4000;

    // Quarter-wave sine at peak 31, index 16 first (2 dB below the high table).
    localparam logic [16:0][5:0] LO_TAB = {
        6'h1F, 6'h1F, 6'h1E, 6'h1E, 6'h1D, 6'h1B, 6'h1A, 6'h18, 6'h16,
        6'h14, 6'h11, 6'h0F, 6'h0C, 6'h09, 6'h06, 6'h03, 6'h00};
    // Quarter-wave sine at peak 39, index 16 first.
    localparam logic [16:0][6:0] HI_TAB = {
        7'h27, 7'h27, 7'h26, 7'h25, 7'h24, 7'h22, 7'h20, 7'h1E, 7'h1C,
        7'h19, 7'h16, 7'h12, 7'h0F, 7'h0B, 7'h08, 7'h04, 7'h00};

    // State of the tone generator apart from its sample buffer.
    typedef struct packed {
        logic [7:0]          hi_code;
        logic [7:0]          lo_code;
        logic [PHASE_W-1:0]  hi_phase;
        logic [PHASE_W-1:0]  lo_phase;
        logic                fs_meta;
        logic                fs_sync;
        logic                fs_prev;
        logic                pend;
        logic [SAMPLE_W-1:0] pend_data;
        logic [SAMPLE_W-1:0] dac;
        logic [16:0]         sd_err;
        logic                pdm;
        logic [7:0]          rdata;
    } dtg_state_type;

endpackage

// ==== rtl/dtg_stream_if.sv ====
`timescale 1ns/1ns
// Carries samples between the generator and its buffer.
interface dtg_stream_if #(
    parameter int WIDTH = 15
);
    logic             push_valid; // Generator offers a sample.
    logic             push_ready; // Buffer has room.
    logic [WIDTH-1:0] push_data;  // Offered sample.
    logic             pop_valid;  // Buffer holds a sample.
    logic             pop_ready;  // Consumer takes the sample.
    logic [WIDTH-1:0] pop_data;   // Oldest buffered sample.

    // The generator fills and drains the buffer.
    modport gen  (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data);
    // The buffer side.
    modport fifo (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data);
endinterface

// ==== rtl/dtg_fifo.sv ====
`timescale 1ns/1ns
// Small first-in first-out buffer with valid and ready on both sides.
module dtg_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 4
) (
    input  wire logic mclk_i,
    input  wire logic rst_n_i,
    dtg_stream_if.fifo s
);
    localparam int AW = $clog2(DEPTH);

    // Whole buffer state in one record.
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wptr;
        logic [AW-1:0]               rptr;
        logic [AW:0]                 count;
    } dtg_fifo_state_type;

    dtg_fifo_state_type st_reg;   // Registered state.
    dtg_fifo_state_type st_next;  // Next state.
    logic               do_push;  // A sample enters this cycle.
    logic               do_pop;   // A sample leaves this cycle.

    // Full and empty come straight from the occupancy count.
    assign s.push_ready = (st_reg.count != (AW+1)'(DEPTH));
    assign s.pop_valid  = (st_reg.count != '0);
    assign s.pop_data   = st_reg.mem[st_reg.rptr];
    assign do_push      = s.push_valid && s.push_ready;
    assign do_pop       = s.pop_valid && s.pop_ready;

    // Pointers wrap at the depth; a push and a pop together leave the count alone.
    always_comb begin
        st_next = st_reg;
        if (do_push) begin
            st_next.mem[st_reg.wptr] = s.push_data;
            st_next.wptr = (st_reg.wptr == AW'(DEPTH-1)) ? '0 : AW'(st_reg.wptr + 1'b1);
        end
        if (do_pop) begin
            st_next.rptr = (st_reg.rptr == AW'(DEPTH-1)) ? '0 : AW'(st_reg.rptr + 1'b1);
        end
        st_next.count = (AW+1)'(st_reg.count + (do_push ? 1'b1 : 1'b0) - (do_pop ? 1'b1 : 1'b0));
    end

    // State register.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // The count never exceeds the depth.
    fifo_bound_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        st_reg.count <= (AW+1)'(DEPTH))
        else $error("fifo count above depth");
endmodule

// ==== rtl/dtg_tone_gen.sv ====
`timescale 1ns/1ns
// Behaviour
// - Code zero is silence; others select tone.
// - Tone reaches all outputs, gated per port.
// - High and low codes held separately.
// - Code write restarts table look-up for tone.
// - High-register tone is 2 dB louder.
// - Low-tone samples stay within +31 and -32.
// - High-tone samples stay within +39 and -40.
// - Widen amplitude: two top bits, seven zeros.
// - Buzzer output is single-ended density bit stream.
// - Buzzer tone taken after receive path.
// - Receive sample fed to modulator, drives buzzer.
// - Samples made once per frame sync while the pending slot is free.
module dtg_tone_gen (
    input  wire logic        mclk_i,           // Master clock.
    input  wire logic        rst_n_i,          // Asynchronous reset, active low.
    input  wire logic        frame_sync_i,     // Frame synchronisation pin, 8 kHz.
    input  wire logic        reg_wr_i,         // Register write strobe.
    input  wire logic        reg_rd_i,         // Register read strobe.
    input  wire logic [7:0]  reg_addr_i,       // Register address.
    input  wire logic [7:0]  reg_wdata_i,      // Register write data.
    output logic      [7:0]  reg_rdata_o,      // Register read data, one cycle after the strobe.
    input  wire logic        rx_en_i,          // Receive output port enable.
    input  wire logic        buzz_en_i,        // Buzzer output port enable.
    input  wire logic        rx_ready_i,       // Receive path takes a sample.
    output logic             rx_valid_o,       // A sample is offered to the receive path.
    output logic      [14:0] rx_sample_o,      // Dual-tone linear sample.
    output logic             buzzer_pdm_out_o  // Pulse-density buzzer drive.
);
    localparam int SW = dtg_pkg::SAMPLE_W;
    localparam int PW = dtg_pkg::PHASE_W;

    dtg_pkg::dtg_state_type st_reg;   // Registered state.
    dtg_pkg::dtg_state_type st_next;  // Next state.
    dtg_stream_if #(.WIDTH(SW)) buf_if ();

    logic          tick;      // One-cycle pulse at each rising frame sync edge.
    logic          wr_hi;     // Write to the high-tone code.
    logic          wr_lo;     // Write to the low-tone code.
    logic [6:0]    hi_amp;    // Current high-tone amplitude.
    logic [5:0]    lo_amp;    // Current low-tone amplitude.
    logic [SW-1:0] mix;       // Summed and widened sample.
    logic          pop_fire;  // Receive path takes a sample this cycle.
    logic [16:0]   sd_fb;     // Modulator feedback term.
    logic [16:0]   sd_sum;    // Modulator integrator input.

    // Looks up a signed sine amplitude from the quarter-wave tables.
    function automatic logic [6:0] tone_amp(input logic [PW-1:0] ph, input logic code_nz, input logic hi);
        logic [4:0] k;
        logic [4:0] idx;
        logic [6:0] mag;
        k   = {1'b0, ph[PW-3:PW-6]};
        idx = ph[PW-2] ? 5'(5'h10 - k) : k;
        mag = hi ? dtg_pkg::HI_TAB[idx] : {1'b0, dtg_pkg::LO_TAB[idx]};
        if (!code_nz) begin
            mag = '0;
        end
        return ph[PW-1] ? 7'(-mag) : mag;
    endfunction

    // Sign-fills two top bits and appends the zero padding below.
    function automatic logic [SW-1:0] widen(input logic [6:0] amp);
        return {amp[6], amp, {dtg_pkg::PAD_LSB{1'b0}}};
    endfunction

    // Register strobes decoded from the printed addresses.
    assign wr_hi = reg_wr_i && (reg_addr_i == dtg_pkg::HI_TONE_OFS);
    assign wr_lo = reg_wr_i && (reg_addr_i == dtg_pkg::LO_TONE_OFS);
    // Frame edge taken from the synchronised copy only.
    assign tick  = st_reg.fs_sync && !st_reg.fs_prev;

    // Each source has its own code and phase feeding its own look-up.
    assign hi_amp = tone_amp(st_reg.hi_phase, st_reg.hi_code != '0, 1'b1);
    assign lo_amp = 6'(tone_amp(st_reg.lo_phase, st_reg.lo_code != '0, 1'b0));
    assign mix    = SW'(widen(hi_amp) + widen({lo_amp[5], lo_amp}));

    // Buffer hookup; the receive path drains it.
    assign buf_if.push_valid = st_reg.pend;
    assign buf_if.push_data  = st_reg.pend_data;
    assign buf_if.pop_ready  = rx_ready_i;
    assign pop_fire          = buf_if.pop_valid && rx_ready_i;

    // A disabled receive port sees silence but the stream keeps flowing.
    assign rx_valid_o  = buf_if.pop_valid;
    assign rx_sample_o = rx_en_i ? buf_if.pop_data : '0;
    assign reg_rdata_o = st_reg.rdata;
    assign buzzer_pdm_out_o = st_reg.pdm;

    // Modulator loop: plus or minus full scale fed back by the sign bit of the last integrator value.
    assign sd_fb  = st_reg.sd_err[16] ? 17'(-dtg_pkg::SD_FS) : dtg_pkg::SD_FS;
    assign sd_sum = 17'(st_reg.sd_err + {{2{st_reg.dac[SW-1]}}, st_reg.dac} - sd_fb);

    // Sample buffer in front of the receive path.
    dtg_fifo #(
        .WIDTH (SW),
        .DEPTH (dtg_pkg::FIFO_DEPTH)
    ) u_fifo (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .s       (buf_if.fifo)
    );

    // Next-state logic for registers, sequencing and modulator.
    always_comb begin
        st_next = st_reg;
        // Two-stage synchroniser on the frame sync pin, then an edge history bit.
        st_next.fs_meta = frame_sync_i;
        st_next.fs_sync = st_reg.fs_meta;
        st_next.fs_prev = st_reg.fs_sync;
        // A taken sample frees the pending slot.
        if (buf_if.push_ready) begin
            st_next.pend = 1'b0;
        end
        // On a frame edge with the slot free, sample and advance both phases.
        if (tick && !st_reg.pend) begin
            st_next.pend      = 1'b1;
            st_next.pend_data = mix;
            st_next.hi_phase  = PW'(st_reg.hi_phase + st_reg.hi_code);
            st_next.lo_phase  = PW'(st_reg.lo_phase + st_reg.lo_code);
        end
        // A code write restarts that source from the table start.
        if (wr_hi) begin
            st_next.hi_code  = reg_wdata_i;
            st_next.hi_phase = '0;
        end
        if (wr_lo) begin
            st_next.lo_code  = reg_wdata_i;
            st_next.lo_phase = '0;
        end
        // Read data is registered; unmapped addresses read zero.
        if (reg_rd_i) begin
            if (reg_addr_i == dtg_pkg::HI_TONE_OFS) begin
                st_next.rdata = st_reg.hi_code;
            end else if (reg_addr_i == dtg_pkg::LO_TONE_OFS) begin
                st_next.rdata = st_reg.lo_code;
            end else begin
                st_next.rdata = '0;
            end
        end
        // The converter holds the sample last taken by the receive path.
        if (pop_fire) begin
            st_next.dac = buf_if.pop_data;
        end
        // First-order modulator turns the receive sample into one bit per clock.
        st_next.sd_err = sd_sum;
        st_next.pdm    = !sd_sum[16] && buzz_en_i;
    end

    // State register with constant reset values.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg         <= '0;
            st_reg.hi_code <= dtg_pkg::CODE_RST;
            st_reg.lo_code <= dtg_pkg::CODE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // All checks below use the master clock and reset.
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    // A zero code yields a zero amplitude.
    silence_code_a: assert property (st_reg.lo_code == '0 && st_reg.hi_code == '0 |-> mix == '0)
        else $error("zero codes gave a non-zero sample");
    // A disabled buzzer port stays low from the next cycle.
    buzz_gate_a: assert property (!buzz_en_i |=> !buzzer_pdm_out_o)
        else $error("buzzer active while disabled");
    // Writing the high code leaves the low code untouched.
    codes_indep_a: assert property (wr_hi && !wr_lo |=> $stable(st_reg.lo_code))
        else $error("high write disturbed low code");
    // A write restarts the phase of that source.
    phase_restart_a: assert property (wr_lo |=> st_reg.lo_phase == '0 && st_reg.lo_code == $past(reg_wdata_i))
        else $error("low write did not restart phase");
    // Same code and phase: the high source is at least as large.
    hi_louder_a: assert property (st_reg.hi_phase == st_reg.lo_phase && st_reg.hi_code == st_reg.lo_code
        |-> ($signed(hi_amp) >= 0 ? $signed(hi_amp) >= $signed(lo_amp) : $signed(hi_amp) <= $signed(lo_amp)))
        else $error("high tone not louder");
    // Low amplitude range.
    lo_range_a: assert property ($signed(lo_amp) <= dtg_pkg::LO_MAX && $signed(lo_amp) >= dtg_pkg::LO_MIN)
        else $error("low amplitude out of range");
    // High amplitude range.
    hi_range_a: assert property ($signed(hi_amp) <= dtg_pkg::HI_MAX && $signed(hi_amp) >= dtg_pkg::HI_MIN)
        else $error("high amplitude out of range");
    // Low seven bits of every pending sample are zero.
    pad_zero_a: assert property (st_reg.pend |-> st_reg.pend_data[6:0] == '0)
        else $error("sample padding not zero");
    // The converter takes exactly the sample the receive path accepted.
    dac_source_a: assert property (pop_fire |=> st_reg.dac == $past(buf_if.pop_data))
        else $error("converter sample mismatch");
    // A frame edge with a free slot advances the phase by the code.
    phase_step_a: assert property (tick && !st_reg.pend && !wr_lo
        |=> st_reg.lo_phase == PW'($past(st_reg.lo_phase) + $past(st_reg.lo_code)))
        else $error("phase did not advance by code");
    // Without a frame edge or write the phase holds.
    phase_hold_a: assert property (!tick && !wr_hi |=> $stable(st_reg.hi_phase))
        else $error("phase moved between frames");
    // A steady non-negative input never holds the enabled modulator low for more than one bit.
    pdm_ones_a: assert property ((buzz_en_i && !st_reg.dac[SW-1] && $stable(st_reg.dac)) [*4]
        |-> ##[0:1] buzzer_pdm_out_o)
        else $error("modulator not following input");

    // A sample is offered and taken.
    sample_flow_c: cover property (tick ##[1:4] pop_fire);
    // The buffer fills under a stalled receive path.
    fifo_full_c: cover property (!buf_if.push_ready && st_reg.pend);
    // A dual tone is playing.
    dual_tone_c: cover property (st_reg.hi_code != '0 && st_reg.lo_code != '0 && tick);
    // The buzzer toggles.
    buzz_toggle_c: cover property (buzzer_pdm_out_o ##1 !buzzer_pdm_out_o);
endmodule

// ==== verif/dtg_rx_model.sv ====
`timescale 1ns/1ns
// Stand-in for the receive path: takes samples promptly, slowly or not at all.
module dtg_rx_model (
    input  wire logic       mclk_i,     // Master clock.
    input  wire logic [1:0] mode_i,     // Zero prompt, one slow, two stalled.
    output logic            rx_ready_o  // Accepts the offered sample.
);
    int seed = 37; // Fixed seed for the slow acceptance pattern.

    // Ready only moves after the falling edge, well clear of the sampling edge.
    always @(negedge mclk_i) begin
        case (mode_i)
            2'h0:    rx_ready_o <= 1'b1;                     // Prompt consumer.
            2'h1:    rx_ready_o <= (($random(seed) & 3) == 0); // Takes about one cycle in four.
            default: rx_ready_o <= 1'b0;                     // Stalled, so the buffer fills.
        endcase
    end
endmodule

// ==== verif/dtg_tone_gen_bench.sv ====
`timescale 1ns/1ns
// Self-checking bench: a queue model of the tone mixer is compared with every taken sample.
module dtg_tone_gen_bench;
    logic        mclk_i = 1'b0;       // Master clock, 100 ns period.
    logic        rst_n_i = 1'b0;      // Reset, active low.
    logic        frame_sync_i = 1'b0; // Frame pulse, spacing shortened to keep the run brief.
    logic        reg_wr_i = 1'b0;     // Write strobe.
    logic        reg_rd_i = 1'b0;     // Read strobe.
    logic [7:0]  reg_addr_i = 8'h00;  // Register address.
    logic [7:0]  reg_wdata_i = 8'h00; // Register write data.
    logic        rx_en_i = 1'b1;      // Receive port enable.
    logic        buzz_en_i = 1'b1;    // Buzzer port enable.
    logic [1:0]  mode = 2'h0;         // Pace of the receive stand-in.
    logic        rx_ready_i;          // From the receive stand-in.
    logic [7:0]  reg_rdata_o;         // Read data.
    logic        rx_valid_o;          // Sample offered.
    logic [14:0] rx_sample_o;         // Offered sample.
    logic        buzzer_pdm_out_o;    // Buzzer bit stream.
    int          err_total = 0;       // Mismatches seen.
    int          total_checks = 0;    // Comparisons made.
    int          seed = 37;           // Fixed random seed.
    int          hc, lc, hp, lp;      // Model codes and phases.
    int          want, ones, k;       // Scratch values.
    int          exp_q[$];            // Samples made but not yet taken.
    logic [7:0]  d;                   // Random code.
    // DTMF codes, each the tone frequency over the 7.8125 Hz step, rounded.
    logic [7:0]  low_codes[4] = '{8'h59, 8'h63, 8'h6d, 8'h78};
    logic [7:0]  high_codes[4] = '{8'h9b, 8'hab, 8'hbd, 8'hd1};

    dtg_tone_gen i_dtg_tone_gen (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .frame_sync_i(frame_sync_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .rx_en_i(rx_en_i), .buzz_en_i(buzz_en_i), .rx_ready_i(rx_ready_i),
        .rx_valid_o(rx_valid_o), .rx_sample_o(rx_sample_o), .buzzer_pdm_out_o(buzzer_pdm_out_o));
    dtg_rx_model i_dtg_rx_model (.mclk_i(mclk_i), .mode_i(mode), .rx_ready_o(rx_ready_i));

    // The clock toggles every half period.
    always #50 mclk_i = ~mclk_i;

    // Compares one value and counts the result.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // One-cycle write strobe; the model restarts that tone's phase as well.
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge mclk_i);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = v;
        @(negedge mclk_i);
        reg_wr_i = 1'b0;
        if (a == dtg_pkg::HI_TONE_OFS) begin
            hc = v;
            hp = 0;
        end else if (a == dtg_pkg::LO_TONE_OFS) begin
            lc = v;
            lp = 0;
        end
    endtask

    // One-cycle read strobe; data is looked at the cycle after.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge mclk_i);
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        @(negedge mclk_i);
        reg_rd_i = 1'b0;
        check("register read", {24'h00_0000, reg_rdata_o}, {24'h00_0000, exp});
    endtask

    // Table amplitude of a ten-bit phase, built from the quarter wave by symmetry.
    function automatic int amp(input int ph, input bit hi);
        int idx;
        int i;
        int v;
        idx = ph >> 4;
        i = idx[4] ? 16 - (idx % 16) : idx % 16;
        v = hi ? int'(dtg_pkg::HI_TAB[i]) : int'(dtg_pkg::LO_TAB[i]);
        return idx[5] ? -v : v;
    endfunction

    // One frame pulse; a frame that finds the buffer and the holding slot full is lost.
    task automatic frame();
        @(negedge mclk_i);
        frame_sync_i = 1'b1;
        if (exp_q.size() < dtg_pkg::FIFO_DEPTH + 1) begin
            exp_q.push_back(((amp(hp, 1'b1) + amp(lp, 1'b0)) * 128) & 32'h0000_7fff);
            hp = (hp + hc) % 1024;
            lp = (lp + lc) % 1024;
        end
        repeat (4) @(negedge mclk_i);
        frame_sync_i = 1'b0;
        repeat (46) @(negedge mclk_i);
    endtask

    // Every sample taken by the receive path is compared with the model.
    always @(posedge mclk_i) begin
        if (rst_n_i && rx_valid_o === 1'b1 && rx_ready_i === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("unexpected sample", 32'h0000_0001, 32'h0000_0000);
            end else begin
                want = exp_q.pop_front();
                check("rx sample", {17'h0_0000, rx_sample_o}, rx_en_i ? want : 32'h0000_0000);
            end
        end
    end

    // Cuts a hang short well after the tests should have ended.
    initial begin
        #4_000_000;
        err_total++;
        $display("watchdog expired");
        stop_test();
    end

    // Main sequence.
    initial begin
        hc = 0; lc = 0; hp = 0; lp = 0;
        repeat (16) @(negedge mclk_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge mclk_i);
        rd(dtg_pkg::HI_TONE_OFS, dtg_pkg::CODE_RST);
        rd(dtg_pkg::LO_TONE_OFS, dtg_pkg::CODE_RST);
        rd(8'h07, 8'h00);
        // The two codes are held apart.
        for (k = 0; k < 4; k++) begin
            d = $random(seed);
            wr(dtg_pkg::HI_TONE_OFS, d);
            wr(dtg_pkg::LO_TONE_OFS, ~d);
            rd(dtg_pkg::HI_TONE_OFS, d);
            rd(dtg_pkg::LO_TONE_OFS, ~d);
        end
        // Silence, then four DTMF pairs, each low code with the high code at the same index, high group in the high register.
        wr(dtg_pkg::HI_TONE_OFS, 8'h00);
        wr(dtg_pkg::LO_TONE_OFS, 8'h00);
        repeat (3) frame();
        for (k = 0; k < 4; k++) begin
            wr(dtg_pkg::LO_TONE_OFS, low_codes[k]);
            wr(dtg_pkg::HI_TONE_OFS, high_codes[k]);
            repeat (8) frame();
        end
        // The same code in both registers: phases run together, so the high tone is the louder one.
        wr(dtg_pkg::HI_TONE_OFS, 8'h2d);
        wr(dtg_pkg::LO_TONE_OFS, 8'h2d);
        repeat (4) frame();
        // Random codes with a slow receive path.
        mode = 2'h1;
        for (k = 0; k < 6; k++) begin
            wr(dtg_pkg::HI_TONE_OFS, 8'($random(seed)));
            wr(dtg_pkg::LO_TONE_OFS, 8'($random(seed)));
            repeat (6) frame();
        end
        // Stalled receive path: buffer and slot fill, later frames are lost.
        mode = 2'h2;
        repeat (10) @(negedge mclk_i);
        repeat (8) frame();
        check("valid while full", {31'h0, rx_valid_o}, 32'h0000_0001);
        mode = 2'h0;
        repeat (10) @(negedge mclk_i);
        repeat (4) frame();
        // Receive port disabled: the stream flows but carries zeros.
        rx_en_i = 1'b0;
        repeat (3) frame();
        rx_en_i = 1'b1;
        // Buzzer port disabled stays low.
        buzz_en_i = 1'b0;
        ones = 0;
        repeat (2) @(negedge mclk_i);
        repeat (100) @(negedge mclk_i) ones += buzzer_pdm_out_o;
        check("buzzer off", ones, 32'h0000_0000);
        // Silent receive sample gives an even bit density.
        buzz_en_i = 1'b1;
        wr(dtg_pkg::HI_TONE_OFS, 8'h00);
        wr(dtg_pkg::LO_TONE_OFS, 8'h00);
        repeat (8) frame();
        ones = 0;
        repeat (100) @(negedge mclk_i) ones += buzzer_pdm_out_o;
        check("buzzer density", {31'h0, ones >= 48 && ones <= 52}, 32'h0000_0001);
        check("samples left", exp_q.size(), 32'h0000_0000);
        stop_test();
    end
endmodule
